/* File: logic/maq_pkg.sv */
// shared constants and carrier types for the alarm qualify and mask block
package maq_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG0 = 8'h4C;
    localparam logic [7:0] IDX_CFG1 = 8'h4D;
    localparam logic [7:0] IDX_AEN  = 8'h4E;
    localparam logic [7:0] IDX_STAT = 8'h4F;

    localparam logic [15:0] CFG0_RST = 16'h0000;
    localparam logic [15:0] CFG1_RST = 16'h0070;
    localparam logic [15:0] AEN_RST  = 16'h0000;

    // writable bits; all others are reserved and read zero
    localparam logic [15:0] CFG0_WMASK = 16'h0200;
    localparam logic [15:0] CFG1_WMASK = 16'h03F8;
    localparam logic [15:0] AEN_WMASK  = 16'h7FFC;

    // field positions
    localparam int PIN_EN_BIT    = 9;
    localparam int RATE_LSB      = 8;
    localparam int CHAN_QUAL_LSB = 5;
    localparam int TEMP_QUAL_LSB = 3;
    localparam int LATCH_DIS_BIT = 2;

    // alarm sources, aligned with enable bits 14..3; bit 0 is thermal
    localparam int NSRC        = 15;
    localparam int THERMAL_BIT = 0;
    localparam logic [NSRC-1:0] CHAN_SRC_MASK = 15'h7800;

    localparam logic [8:0] CNT_MAX    = 9'h100;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic            valid;
        logic [NSRC-1:0] oor;
    } maq_sample_t;

    typedef struct packed {
        logic [15:0]           cfg0;
        logic [15:0]           cfg1;
        logic [15:0]           aen;
        logic [NSRC-1:0]       oor;
        logic [NSRC-1:0][8:0]  cnt;
        logic [NSRC-1:0]       flag;
        logic                  alarm_n;
        logic [2:0]            div;
        logic                  conv_tick;
        logic                  dwr;
        logic [7:0]            didx;
        logic [31:0]           rdata;
    } maq_state_t;

    function automatic logic [8:0] chan_qual_n(input logic [2:0] sel);
        // shift count is one bit wider than sel so that code 7 reaches 256
        chan_qual_n = (sel == 3'h0) ? 9'h001 : 9'(10'h001 << ({1'b0, sel} + 4'h1));
    endfunction

    function automatic logic [8:0] temp_qual_n(input logic [1:0] sel);
        temp_qual_n = 9'(9'h001 << sel);
    endfunction

    function automatic logic [2:0] rate_mask(input logic [1:0] sel);
        rate_mask = 3'(4'h1 << sel) - 3'h1;
    endfunction

endpackage

/* File: logic/maq_monitor_alarm.sv */
// alarm qualification, pin masking and rate select with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

module maq_monitor_alarm
    import maq_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        adc_base_tick,
    input  wire maq_sample_t sample,
    output logic             adc_conv_tick,
    output logic             alarm_n
);

    maq_state_t s;
    maq_state_t n;

    logic            take;
    logic            addr_ok;
    logic [7:0]      aidx;
    logic            rd;
    logic            stat_rd;
    logic            pin_en;
    logic            latch_dis;
    logic [NSRC-1:0] gated;

    // zero wait states: every transfer completes in its first data cycle
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    assign take    = hsel && hready && htrans[1];
    assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign aidx    = addr_ok ? haddr[9:2] : 8'h00;
    assign rd      = take && !hwrite;
    assign stat_rd = rd && (aidx == IDX_STAT);

    always_comb begin
        logic [8:0] lim;
        logic       hit;
        lim = 9'h000;
        hit = 1'b0;
        n = s;

        // conversion strobe: one of every 1, 2, 4 or 8 base ticks
        if (adc_base_tick) begin
            n.div = s.div + 3'h1;
        end
        n.conv_tick = adc_base_tick &&
            ((s.div & rate_mask(s.cfg1[RATE_LSB +: 2])) == 3'h0);

        // data phase of a write; reserved bits are masked off on store
        if (s.dwr) begin
            unique case (s.didx)
                IDX_CFG0: begin
                    n.cfg0 = hwdata[15:0] & CFG0_WMASK;
                end
                IDX_CFG1: begin
                    n.cfg1 = hwdata[15:0] & CFG1_WMASK;
                end
                IDX_AEN: begin
                    n.aen = hwdata[15:0] & AEN_WMASK;
                end
                default: begin
                    n.dwr = 1'b0;
                end
            endcase
        end

        n.dwr  = take && hwrite && (hsize == HSIZE_WORD);
        n.didx = aidx;

        // read data is taken from the updated copy so a write just before
        // a read of the same register is seen
        if (rd) begin
            unique case (aidx)
                IDX_CFG0: begin
                    n.rdata = {16'h0000, n.cfg0};
                end
                IDX_CFG1: begin
                    n.rdata = {16'h0000, n.cfg1};
                end
                IDX_AEN: begin
                    n.rdata = {16'h0000, n.aen};
                end
                IDX_STAT: begin
                    n.rdata = {17'h00000, s.flag};
                end
                default: begin
                    n.rdata = 32'h00000000;
                end
            endcase
        end

        latch_dis = n.aen[LATCH_DIS_BIT];

        for (int i = 0; i < NSRC; i++) begin
            if (sample.valid) begin
                n.oor[i] = sample.oor[i];
                if (!sample.oor[i]) begin
                    n.cnt[i] = 9'h000;
                end else if (s.cnt[i] != CNT_MAX) begin
                    n.cnt[i] = s.cnt[i] + 9'h001;
                end
            end
            if (CHAN_SRC_MASK[i]) begin
                lim = chan_qual_n(n.cfg1[CHAN_QUAL_LSB +: 3]);
            end else begin
                lim = temp_qual_n(n.cfg1[TEMP_QUAL_LSB +: 2]);
            end
            hit = n.oor[i] && (n.cnt[i] >= lim);
            if (latch_dis) begin
                n.flag[i] = hit;
            end else begin
                // a read clears only once the condition has gone; set wins
                if (stat_rd && !n.oor[i]) begin
                    n.flag[i] = 1'b0;
                end
                if (hit) begin
                    n.flag[i] = 1'b1;
                end
            end
        end

        // masks act on the pin path only; flags above never see them
        gated          = '0;
        gated[14:11]   = s.flag[14:11] & s.aen[14:11];
        gated[10:9]    = s.flag[10:9] & s.aen[10:9];
        gated[8:5]     = s.flag[8:5] & s.aen[8:5];
        gated[4:3]     = s.flag[4:3] & s.aen[4:3];
        pin_en         = s.cfg0[PIN_EN_BIT];
        n.alarm_n      = !(pin_en && ((|gated) || s.flag[THERMAL_BIT]));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.cfg0      <= CFG0_RST;
            s.cfg1      <= CFG1_RST;
            s.aen       <= AEN_RST;
            s.oor       <= '0;
            s.cnt       <= '0;
            s.flag      <= '0;
            s.alarm_n   <= 1'b1;
            s.div       <= 3'h0;
            s.conv_tick <= 1'b0;
            s.dwr       <= 1'b0;
            s.didx      <= 8'h00;
            s.rdata     <= 32'h00000000;
        end else begin
            s <= n;
        end
    end

    assign hrdata        = s.rdata;
    assign adc_conv_tick = s.conv_tick;
    assign alarm_n       = s.alarm_n;

    a_rate_full: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s.cfg1[RATE_LSB +: 2] == 2'h0) && adc_base_tick |=> adc_conv_tick
    ) else $error("full rate tick missing");

    a_rate_eighth: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (s.cfg1[RATE_LSB +: 2] == 2'h3) && adc_base_tick && (s.div != 3'h0)
        |=> !adc_conv_tick
    ) else $error("eighth rate tick too often");

    a_chan_single: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (n.cfg1[CHAN_QUAL_LSB +: 3] == 3'h0) && sample.valid && sample.oor[14]
        |=> s.flag[14]
    ) else $error("channel 0 flag not set after one sample");

    a_temp_single: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (n.cfg1[TEMP_QUAL_LSB +: 2] == 2'h0) && sample.valid && sample.oor[10]
        |=> s.flag[10]
    ) else $error("local under flag not set after one sample");

    a_rsvd_zero: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rd && (aidx == IDX_CFG1)
        |=> (hrdata[31:10] == 22'h0) && (hrdata[2:0] == 3'h0)
    ) else $error("reserved bits read nonzero");

    a_therm_pin: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[THERMAL_BIT] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("thermal flag did not pull pin low");

    a_pin_off: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !s.cfg0[PIN_EN_BIT] |=> alarm_n
    ) else $error("pin asserted while disabled");

    a_mask_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ((s.flag & s.aen[14:0] & 15'h7FF8) == 15'h0) && !s.flag[THERMAL_BIT]
        |=> alarm_n
    ) else $error("masked flag reached pin");

    a_count_clear: assert property (
        @(posedge hclk) disable iff (!hresetn)
        sample.valid && !sample.oor[11] |=> (s.cnt[11] == 9'h000)
    ) else $error("counter not cleared on good sample");

    a_unlatched_drop: assert property (
        @(posedge hclk) disable iff (!hresetn)
        n.aen[LATCH_DIS_BIT] && sample.valid && !sample.oor[9] |=> !s.flag[9]
    ) else $error("unlatched flag held after condition ended");

    a_chan0_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[14] && s.aen[14] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("channel 0 alarm did not reach pin");

    a_chan1_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[13] && s.aen[13] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("channel 1 alarm did not reach pin");

    a_chan2_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[12] && s.aen[12] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("channel 2 alarm did not reach pin");

    a_chan3_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[11] && s.aen[11] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("channel 3 alarm did not reach pin");

    a_local_low_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[10] && s.aen[10] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("local under alarm did not reach pin");

    a_local_high_gate: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[9] && s.aen[9] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("local over alarm did not reach pin");

    a_diode_a_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[8] && s.aen[8] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode a under alarm did not reach pin");

    a_diode_a_high: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[7] && s.aen[7] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode a over alarm did not reach pin");

    a_diode_b_low: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[6] && s.aen[6] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode b under alarm did not reach pin");

    a_diode_b_high: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[5] && s.aen[5] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode b over alarm did not reach pin");

    a_diode_a_fail: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[4] && s.aen[4] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode a failure alarm did not reach pin");

    a_diode_b_fail: assert property (
        @(posedge hclk) disable iff (!hresetn)
        s.flag[3] && s.aen[3] && s.cfg0[PIN_EN_BIT] |=> !alarm_n
    ) else $error("diode b failure alarm did not reach pin");

    a_flag_unmasked: assert property (
        @(posedge hclk) disable iff (!hresetn)
        (n.cfg1[CHAN_QUAL_LSB +: 3] == 3'h0) && sample.valid && sample.oor[13] && !n.aen[13]
        |=> s.flag[13]
    ) else $error("masked source did not set its flag");

    a_latched_hold: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !n.aen[LATCH_DIS_BIT] && s.flag[14] && !stat_rd
        |=> s.flag[14]
    ) else $error("latched flag dropped without a status read");

    a_bad_survives_read: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !n.aen[LATCH_DIS_BIT] && s.flag[14] && n.oor[14]
        |=> s.flag[14]
    ) else $error("latched flag cleared while condition present");

    a_read_clears: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !n.aen[LATCH_DIS_BIT] && stat_rd && !n.oor[14]
        |=> !s.flag[14]
    ) else $error("status read did not clear resolved flag");

    a_chan_long_count: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !s.flag[13] && sample.valid && (n.cfg1[CHAN_QUAL_LSB +: 3] == 3'h7) && (s.cnt[13] < 9'h0FE)
        |=> !s.flag[13]
    ) else $error("channel 1 flag set before 256 samples");

    a_temp_long_count: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !s.flag[9] && sample.valid && (n.cfg1[TEMP_QUAL_LSB +: 2] == 2'h3) && (s.cnt[9] < 9'h006)
        |=> !s.flag[9]
    ) else $error("local over flag set before 8 samples");

endmodule

`default_nettype wire

/* File: tb/maq_monitor_alarm_bench.sv */
// self-checking bench for the alarm qualify and mask block
`timescale 1ns/1ps
`default_nettype none
module maq_monitor_alarm_bench;
    import maq_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, base = 0, pin, exp_n;
    logic [31:0] haddr = '0, hwdata = '0, rd;
    logic [1:0]  htrans = '0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [15:0] wd, aen;
    maq_sample_t smp = '0;
    wire logic   hready, hresp, conv, alarm_n;
    wire logic [31:0] hrdata;
    integer      seed = 59;
    int          error_cnt = 0, comparisons = 0, ticks = 0, b, k, c;

    maq_monitor_alarm dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .adc_base_tick(base),
        .sample(smp), .adc_conv_tick(conv), .alarm_n(alarm_n));

    initial forever #50 hclk = ~hclk;
    // base tick every second cycle, so a window of 64 cycles holds 32 of them
    always @(posedge hclk) base <= ~base;
    always @(posedge hclk) if (conv === 1'h1) ticks <= ticks + 1;

    // model: channel count 1 for code 0, else 2 to the power code plus one
    function automatic int chan_n(input int code);
        return code == 0 ? 1 : 2 << code;
    endfunction

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // single word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] i, input logic [15:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        haddr <= {22'h0, i, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= {16'h0, d};
        do @(posedge hclk); while (hready !== 1'h1);
        rd = hrdata;
        chk("hresp", 32'h0, 32'(hresp));
    endtask

    task automatic send(input logic [14:0] o, input int n);
        repeat (n) begin
            @(posedge hclk);
            smp <= {1'h1, o};
        end
        @(posedge hclk);
        smp <= '0;
    endtask

    // a good sample in the middle restarts the count
    task automatic qual(input int s, input int n);
        send(15'h1 << s, n - 1);
        send(15'h0, 1);
        send(15'h1 << s, n - 1);
        bus(0, IDX_STAT, 0);
        chk("early flag", 0, rd);
        send(15'h1 << s, 1);
        bus(0, IDX_STAT, 0);
        chk("qual flag", 32'h1 << s, rd);
        send(15'h0, 1);
        bus(0, IDX_STAT, 0);
        chk("unlatched", 0, rd);
    endtask

    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'h1;
        chk("alarm reset", 32'h1, 32'(alarm_n));
        bus(0, IDX_CFG0, 0);
        chk("cfg0 reset", 32'(CFG0_RST), rd);
        bus(0, IDX_CFG1, 0);
        chk("cfg1 reset", 32'h0070, rd);
        bus(0, IDX_AEN, 0);
        chk("aen reset", 32'h0, rd);
        bus(0, 8'h50, 0);
        chk("unmapped", 32'h0, rd);
        for (k = 0; k < 3; k++) begin
            wd = 16'($random(seed)) | 16'h8007;
            bus(1, IDX_CFG0 + 8'(k), wd);
            bus(0, IDX_CFG0 + 8'(k), 0);
            chk("reg rw", 32'(wd & (k == 0 ? CFG0_WMASK : k == 1 ? CFG1_WMASK : AEN_WMASK)),
                rd);
        end
        for (k = 0; k < 4; k++) begin
            bus(1, IDX_CFG1, 16'(k << 8));
            repeat (4) @(posedge hclk);
            c = ticks;
            repeat (64) @(posedge hclk);
            chk("conv ticks", 32'(32 >> k), 32'(ticks - c));
        end
        bus(1, IDX_AEN, 16'h0004);
        for (k = 0; k < 8; k++) begin
            bus(1, IDX_CFG1, 16'({k[1:0], k[2:0], k[1:0], 3'h0}));
            qual(13, chan_n(k));
            qual(9, 1 << k[1:0]);
        end
        bus(1, IDX_CFG1, 16'h0000);
        for (b = 14; b >= 0; b--) begin
            if (b == 1 || b == 2) continue;
            // k 0 masked, 1 enabled, 2 enabled with the pin itself off
            for (k = 0; k < 3; k++) begin
                pin = (k != 2);
                aen = (16'($random(seed)) & 16'h7FF8 & ~(16'h1 << b)) | 16'h0004;
                aen = aen | (16'(k != 0) << b);
                bus(1, IDX_CFG0, {6'h0, pin, 9'h0});
                bus(1, IDX_AEN, aen);
                send(15'h1 << b, 1);
                repeat (2) @(posedge hclk);
                exp_n = !(pin && (b == 0 || aen[b]));
                chk("alarm pin", 32'(exp_n), 32'(alarm_n));
                bus(0, IDX_STAT, 0);
                chk("flag", 32'h1 << b, rd);
                send(15'h0, 1);
            end
        end
        bus(1, IDX_AEN, 16'h0000);
        send(15'h4000, 1);
        send(15'h0, 1);
        bus(0, IDX_STAT, 0);
        chk("latched", 32'h4000, rd);
        bus(0, IDX_STAT, 0);
        chk("read clear", 32'h0, rd);
        tally_and_finish;
    end

    // the run needs about 2300 cycles; a hang is cut well past that
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        tally_and_finish;
    end
endmodule
`default_nettype wire
